// [dv/isc_bus_master.sv]
// isc_bus_master: behavioural i2c master on open-drain scl and sda
// assumes the bench resolves both wires with pull-ups and feeds them back
`timescale 1ns/1ps
`default_nettype none
module isc_bus_master #(
  parameter int HALF = 25
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  // both lines released at time zero
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // wait a number of pclk edges
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // release scl, tolerate stretching, then keep the high phase
  task automatic scl_up();
    int i;
    i = 0;
    scl_pull <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1 && i < 5000) begin
      @(posedge pclk);
      i++;
    end
    hold(HALF);
  endtask

  // start or repeated start from any line state
  task automatic start();
    sda_pull <= 1'b0;
    hold(HALF);
    scl_up();
    sda_pull <= 1'b1;
    hold(HALF);
    scl_pull <= 1'b1;
    hold(HALF);
  endtask

  // stop, also used to resynchronise after a bus error
  task automatic stop();
    sda_pull <= 1'b1;
    hold(HALF);
    scl_up();
    sda_pull <= 1'b0;
    hold(HALF);
  endtask

  // top n bits, msb first, scl left low
  task automatic bits(input logic [7:0] b, input int n);
    for (int k = 7; k > 7 - n; k--) begin
      sda_pull <= ~b[k];
      hold(HALF);
      scl_up();
      scl_pull <= 1'b1;
      hold(HALF);
    end
  endtask

  // read a byte from the slave, then leave the ninth bit high as a nack
  task automatic get_byte(output logic [7:0] b);
    sda_pull <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      hold(HALF);
      scl_up();
      b[k] = sda;
      scl_pull <= 1'b1;
    end
    hold(HALF);
    scl_up();
    scl_pull <= 1'b1;
    hold(HALF);
  endtask

  // whole byte plus the ninth clock; acked when sda was low
  task automatic put_byte(input logic [7:0] b, output logic acked);
    bits(b, 8);
    sda_pull <= 1'b0;
    hold(HALF);
    scl_up();
    acked = (sda === 1'b0);
    scl_pull <= 1'b1;
    hold(HALF);
  endtask
endmodule
`default_nettype wire

// [dv/isc_core_test.sv]
// isc_core_test: self-checking bench for the register and slave receive paths
// assumes isc_core as top and the bus master model with pull-ups on both wires
`timescale 1ns/1ps
`default_nettype none
module isc_core_test;
  import isc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, scl_oe, sda_oe, irq, m_scl, m_sda, ack, tick;
  logic [1:0] cpu_freq_range;
  logic scl_line, sda_line;
  logic [16:0] expq[$];
  logic [16:0] note;
  logic [31:0] seed, cycles;
  logic [7:0] ccr, d, rx;
  int gap, want;
  int error_cnt = 0;
  int n_compared = 0;

  // open-drain wires with pull-ups
  assign scl_line = !(scl_oe || m_scl);
  assign sda_line = !(sda_oe || m_sda);

  always #5 pclk = ~pclk;

  isc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .irq(irq),
    .cpu_freq_range(cpu_freq_range), .scl_rate_tick(tick));

  isc_bus_master m (.pclk(pclk), .scl(scl_line), .sda(sda_line), .scl_pull(m_scl),
    .sda_pull(m_sda));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // one apb transfer, held until pready at an access edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pclk edges from one rate tick to the next
  task automatic tick_gap(output int n);
    n = 0;
    while (tick !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    n = 1;
    while (tick !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // read: note mask, expected byte and error first
  task automatic rd(input logic [7:0] idx, input logic [7:0] mk, input logic [7:0] e,
                    input logic err);
    expq.push_back({err, mk, e});
    apb(1'b0, idx, 8'h00);
  endtask

  // watcher: compares each finished read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      note = expq.pop_front();
      chk("prdata", {24'h0, note[7:0]}, {prdata[31:8], prdata[7:0] & note[15:8]});
      chk("pslverr", {31'h0, note[16]}, {31'h0, pslverr});
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'd30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    cycles = 32'h0;
    seed = 32'hf565;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("freq_range", 32'h1, {30'h0, cpu_freq_range});
    for (int i = 0; i < 7; i++) begin
      rd(IDX_BUS_CONTROL + 8'(i), 8'hff, (i == 5) ? 8'h40 : 8'h00, 1'b0);
    end
    rd(8'h30, 8'hff, 8'h00, 1'b1);
    seed = xs(seed);
    ccr = seed[7:0];
    apb(1'b1, IDX_CLOCK_CONTROL, ccr);
    apb(1'b1, IDX_OWN_ADDRESS_HIGH, 8'h06);
    rd(IDX_OWN_ADDRESS_HIGH, 8'hff, 8'h06, 1'b0);
    chk("freq_range", 32'h0, {30'h0, cpu_freq_range});
    apb(1'b1, IDX_OWN_ADDRESS_LOW, 8'ha5);
    pstrb <= 4'h0;
    apb(1'b1, IDX_BUS_CONTROL, 8'h25);
    pstrb <= 4'hf;
    rd(IDX_BUS_CONTROL, 8'hff, 8'h00, 1'b0);
    apb(1'b1, IDX_BUS_CONTROL, 8'h35);
    apb(1'b1, IDX_BUS_CONTROL, 8'h01);
    rd(IDX_BUS_CONTROL, 8'hff, 8'h00, 1'b0);
    rd(IDX_CLOCK_CONTROL, 8'hff, ccr, 1'b0);
    rd(IDX_OWN_ADDRESS_LOW, 8'hff, 8'ha5, 1'b0);
    apb(1'b1, IDX_BUS_CONTROL, 8'h35);
    want = ccr[7] ? FAST_BASE_CYC + FAST_STEP_CYC * int'(ccr[6:0])
      : STD_BASE_CYC + STD_STEP_CYC * int'(ccr[6:0]);
    tick_gap(gap);
    chk("rate_gap", 32'(want), 32'(gap));
    // receive: address with opposite bit 0, then two random bytes
    m.start();
    m.put_byte(8'ha4, ack);
    chk("addr_ack", 32'h1, {31'h0, ack});
    rd(IDX_STATUS_FIRST, 8'h34, 8'h14, 1'b0);
    for (int b = 0; b < 2; b++) begin
      seed = xs(seed);
      d = seed[7:0];
      m.put_byte(d, ack);
      chk("data_ack", 32'h1, {31'h0, ack});
      chk("irq", 32'h1, {31'h0, irq});
      chk("scl_held", 32'h1, {31'h0, scl_oe});
      rd(IDX_BYTE_BUFFER, 8'hff, d, 1'b0);
    end
    // misplaced start three bits into a byte
    m.bits(8'hff, 3);
    m.start();
    chk("scl_free", 32'h0, {31'h0, scl_oe});
    chk("irq", 32'h1, {31'h0, irq});
    rd(IDX_STATUS_FIRST, 8'h10, 8'h00, 1'b0);
    rd(IDX_STATUS_SECOND, 8'h02, 8'h02, 1'b0);
    rd(IDX_STATUS_SECOND, 8'h02, 8'h00, 1'b0);
    m.stop();
    // general call, cleared by stop
    m.start();
    m.put_byte(8'h00, ack);
    rd(IDX_STATUS_SECOND, 8'h01, 8'h01, 1'b0);
    rd(IDX_STATUS_FIRST, 8'h04, 8'h04, 1'b0);
    m.stop();
    rd(IDX_STATUS_SECOND, 8'h0b, 8'h08, 1'b0);
    // ten-bit header then the low address byte
    m.start();
    m.put_byte(8'hf6, ack);
    m.put_byte(8'ha5, ack);
    chk("ten_ack", 32'h1, {31'h0, ack});
    rd(IDX_STATUS_FIRST, 8'h24, 8'h04, 1'b0);
    m.stop();
    // transmit: read address, one random byte, nacked by the master
    m.start();
    m.put_byte(8'ha5, ack);
    rd(IDX_STATUS_FIRST, 8'h24, 8'h24, 1'b0);
    seed = xs(seed);
    d = seed[7:0];
    apb(1'b1, IDX_BYTE_BUFFER, d);
    m.get_byte(rx);
    chk("tx_byte", {24'h0, d}, {24'h0, rx});
    rd(IDX_STATUS_SECOND, 8'h12, 8'h10, 1'b0);
    m.stop();
    // seven-bit address byte 01h is never acknowledged
    apb(1'b1, IDX_OWN_ADDRESS_LOW, 8'h01);
    apb(1'b1, IDX_BUS_CONTROL, 8'h25);
    m.start();
    m.put_byte(8'h01, ack);
    chk("never_ack", 32'h0, {31'h0, ack});
    m.stop();
    repeat (4) @(posedge pclk);
    report_and_stop();
  end
endmodule
`default_nettype wire

// [logic/isc_core.sv]
// isc_core: i2c slave-side status, clock, address and byte buffer registers
// assumes an apb master on pclk and open-drain scl/sda resolved outside
//
// Behaviour
// - misplaced start or stop on the bus sets the bus error flag
// - bus error flag raises the interrupt while interrupt enable is one
// - bus error clears on status_second read or when peripheral is disabled
// - bus error flag alone never holds scl low
// - general call address with recognition enabled sets general call flag
// - general call flag clears on stop or when peripheral is disabled
// - fast mode select picks standard or fast, kept while disabled
// - seven-bit scl divider with mode sets the rate, kept while disabled
// - transmitter: writing the byte buffer starts sending that byte
// - receiver: first data byte lands in the byte buffer automatically
// - receiver: further bytes come only after the byte buffer is read or written
// - own_address_low bits 7:1 hold the seven-bit address, kept while disabled
// - seven-bit match ignores address bit 0, either direction is acknowledged
// - the address byte 01h is never recognised or acknowledged, except as the low byte after a ten-bit header
// - ten-bit address uses own_address_low 7:0 and own_address_high 2:1
// - own_address_high resets to 40h
// - a bus error clears the bus busy indicator
// - interrupt enable gates interrupts and clears when peripheral is disabled
`timescale 1ns/1ps
`default_nettype none
module isc_core
  import isc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int STD_BASE = STD_BASE_CYC,
  parameter int STD_STEP = STD_STEP_CYC,
  parameter int FAST_BASE = FAST_BASE_CYC,
  parameter int FAST_STEP = FAST_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq,
  output logic [1:0] cpu_freq_range,
  output logic scl_rate_tick
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'h0}));
  endfunction

  logic [7:0] ctrl, next_ctrl, ccr, next_ccr, own_lo, next_own_lo, own_hi, next_own_hi;
  logic [31:0] next_prdata;
  logic [7:0] sr1, sr2, dbuf, next_dbuf, shreg, next_shreg;
  logic [3:0] bcnt, next_bcnt;
  isc_state_t st, next_st;
  logic tx_loaded, next_tx_loaded, sda_drv, next_sda_drv;
  logic ten_hdr, next_ten_hdr, ten_ok, next_ten_ok, hdr_pend, next_hdr_pend;
  logic addressed, next_addressed, busy, next_busy, btf, next_btf;
  logic adsl, next_adsl, tra, next_tra, af, next_af;
  logic stop_detected_flag, next_stop_detected_flag, bus_error_flag, next_bus_error_flag, general_call_flag, next_general_call_flag;
  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, start_c, stop_c, misplaced, tx_wait, evf, pe;
  logic a_take, a_hdr, a_rw, a_gc, a_eval;
  logic wr_ok, rd_acc, setup_rd, mapped;

  // apb decode; one wait-free access phase
  assign wr_ok = psel & penable & pwrite & pstrb[0];
  assign rd_acc = psel & penable & ~pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign mapped = hit(paddr, IDX_BUS_CONTROL) | hit(paddr, IDX_STATUS_FIRST)
    | hit(paddr, IDX_STATUS_SECOND) | hit(paddr, IDX_CLOCK_CONTROL)
    | hit(paddr, IDX_OWN_ADDRESS_LOW) | hit(paddr, IDX_OWN_ADDRESS_HIGH)
    | hit(paddr, IDX_BYTE_BUFFER);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign pe = ctrl[CR_PE];

  // status words as software sees them; master-side bits read zero
  assign evf = btf | adsl | af | stop_detected_flag | bus_error_flag;
  assign sr1 = {evf, 1'b0, tra, busy, btf, adsl, 1'b0, 1'b0};
  assign sr2 = {3'h0, af, stop_detected_flag, 1'b0, bus_error_flag, general_call_flag};

  // pin sampling through three stages
  isc_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({scl_i, sda_i}),
    .level({scl_s, sda_s})
  );

  // rate tick for the bus clock generator of the unit
  isc_scl_rate #(
    .STD_BASE(STD_BASE),
    .STD_STEP(STD_STEP),
    .FAST_BASE(FAST_BASE),
    .FAST_STEP(FAST_STEP)
  ) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .enable(pe),
    .fast_mode(ccr[CCR_FAST]),
    .divider(ccr[6:0]),
    .tick(scl_rate_tick)
  );

  // bus conditions; a receive count of one is the legal first high phase after an ack
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  assign misplaced = ((st == ST_ADDR || (st == ST_DATA && !tra)) && bcnt > BCNT_ONE)
    || (st == ST_DATA && tra && bcnt != BCNT_RST) || st == ST_AACK || st == ST_DACK;
  assign tx_wait = (st == ST_DATA) & tra & ~tx_loaded;
  assign a_eval = pe & scl_fall & (st == ST_ADDR) & (bcnt == BCNT_FULL);

  // pin drivers: open drain, only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = pe & (adsl | btf | tx_wait);
  assign sda_oe = sda_drv | ((st == ST_DATA) & tra & tx_loaded
    & (bcnt < BCNT_FULL) & ~dbuf[~bcnt[2:0]]);
  assign irq = ctrl[CR_ITE] & evf;
  assign cpu_freq_range = own_hi[OAH_FR_LSB +: 2];

  // configuration registers
  always_comb begin
    next_ctrl = ctrl;
    next_ccr = ccr;
    next_own_lo = own_lo;
    next_own_hi = own_hi;
    if (wr_ok && hit(paddr, IDX_BUS_CONTROL)) begin
      next_ctrl = pwdata[7:0];
    end
    if (wr_ok && hit(paddr, IDX_CLOCK_CONTROL)) begin
      next_ccr = pwdata[7:0];
    end
    if (wr_ok && hit(paddr, IDX_OWN_ADDRESS_LOW)) begin
      next_own_lo = pwdata[7:0];
    end
    if (wr_ok && hit(paddr, IDX_OWN_ADDRESS_HIGH)) begin
      next_own_hi = pwdata[7:0] & OAH_WMASK;
    end
    if (!next_ctrl[CR_PE]) begin
      next_ctrl[CR_ITE] = 1'b0;
      next_ctrl[CR_ACK] = 1'b0;
    end
  end

  // read data latched in the setup phase
  always_comb begin
    next_prdata = prdata;
    if (setup_rd) begin
      next_prdata = RST_PRDATA;
      if (hit(paddr, IDX_BUS_CONTROL)) next_prdata[7:0] = ctrl;
      if (hit(paddr, IDX_STATUS_FIRST)) next_prdata[7:0] = sr1;
      if (hit(paddr, IDX_STATUS_SECOND)) next_prdata[7:0] = sr2;
      if (hit(paddr, IDX_CLOCK_CONTROL)) next_prdata[7:0] = ccr;
      if (hit(paddr, IDX_OWN_ADDRESS_LOW)) next_prdata[7:0] = own_lo;
      if (hit(paddr, IDX_OWN_ADDRESS_HIGH)) next_prdata[7:0] = own_hi;
      if (hit(paddr, IDX_BYTE_BUFFER)) next_prdata[7:0] = dbuf;
    end
  end

  // address byte evaluation
  always_comb begin
    a_take = 1'b0;
    a_hdr = 1'b0;
    a_rw = shreg[0];
    a_gc = 1'b0;
    if (ten_hdr) begin
      a_take = (shreg == own_lo);
      a_rw = 1'b0;
    end else if (shreg[7:3] == TEN_BIT_TAG && shreg[2:1] == own_hi[OAH_ADDR_LSB +: 2]) begin
      a_hdr = ~shreg[0];
      a_take = ~shreg[0] | ten_ok;
    end else if (shreg == GEN_CALL_ADDR) begin
      a_gc = ctrl[CR_GENERAL_CALL_ENABLE];
      a_take = a_gc;
      a_rw = 1'b0;
    end else begin
      a_take = (shreg[7:1] == own_lo[7:1]);
    end
    if (!ten_hdr && shreg == NEVER_ADDR) begin
      a_take = 1'b0;
    end
  end

  // byte engine and flags; software clears first so a bus set wins
  always_comb begin
    next_st = st;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_dbuf = dbuf;
    next_tx_loaded = tx_loaded;
    next_sda_drv = sda_drv;
    next_ten_hdr = ten_hdr;
    next_ten_ok = ten_ok;
    next_hdr_pend = hdr_pend;
    next_addressed = addressed;
    next_busy = busy;
    next_btf = btf;
    next_adsl = adsl;
    next_tra = tra;
    next_af = af;
    next_stop_detected_flag = stop_detected_flag;
    next_bus_error_flag = bus_error_flag;
    next_general_call_flag = general_call_flag;
    if (rd_acc && hit(paddr, IDX_STATUS_SECOND)) begin
      next_bus_error_flag = 1'b0;
      next_af = 1'b0;
      next_stop_detected_flag = 1'b0;
    end
    if (rd_acc && hit(paddr, IDX_STATUS_FIRST)) next_adsl = 1'b0;
    if (psel && penable && hit(paddr, IDX_BYTE_BUFFER)) next_btf = 1'b0;
    if (wr_ok && hit(paddr, IDX_BYTE_BUFFER)) begin
      next_dbuf = pwdata[7:0];
      next_tx_loaded = 1'b1;
    end
    if (!pe) begin
      next_st = ST_IDLE; // busy keeps its value while disabled
      next_bcnt = BCNT_RST;
      next_tx_loaded = 1'b0;
      next_sda_drv = 1'b0;
      next_ten_hdr = 1'b0;
      next_ten_ok = 1'b0;
      next_addressed = 1'b0;
      next_btf = 1'b0;
      next_adsl = 1'b0;
      next_tra = 1'b0;
      next_af = 1'b0;
      next_stop_detected_flag = 1'b0;
      next_bus_error_flag = 1'b0;
      next_general_call_flag = 1'b0;
    end else if (start_c) begin
      if (misplaced) begin
        next_bus_error_flag = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_busy = 1'b1;
      end
      next_st = ST_ADDR;
      next_bcnt = BCNT_RST;
      next_sda_drv = 1'b0;
      next_tra = 1'b0;
    end else if (stop_c) begin
      if (misplaced) begin
        next_bus_error_flag = 1'b1;
      end else if (addressed) begin
        next_stop_detected_flag = 1'b1;
      end
      next_busy = 1'b0;
      next_general_call_flag = 1'b0;
      next_st = ST_IDLE;
      next_sda_drv = 1'b0;
      next_tra = 1'b0;
      next_ten_hdr = 1'b0;
      next_ten_ok = 1'b0;
      next_addressed = 1'b0;
    end else if (scl_rise) begin
      case (st)
        ST_ADDR: begin
          next_shreg = {shreg[6:0], sda_s};
          next_bcnt = bcnt + 4'h1;
        end
        ST_DATA: begin
          if (!tra) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bcnt = bcnt + 4'h1;
          end
        end
        ST_DACK: begin
          if (tra && sda_s) begin
            next_af = 1'b1;
            next_st = ST_SKIP;
            next_tra = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st)
        ST_ADDR: begin
          if (bcnt == BCNT_FULL) begin
            next_st = ST_SKIP;
            next_ten_hdr = 1'b0;
            if (a_gc) next_general_call_flag = 1'b1;
            if (ten_hdr && a_take) next_ten_ok = 1'b1;
            if (a_take && ctrl[CR_ACK]) begin
              next_st = ST_AACK;
              next_sda_drv = 1'b1;
              next_hdr_pend = a_hdr;
              next_tra = a_rw;
            end
          end
        end
        ST_AACK: begin
          next_sda_drv = 1'b0;
          next_bcnt = BCNT_RST;
          if (hdr_pend) begin
            next_ten_hdr = 1'b1;
            next_st = ST_ADDR;
            next_tra = 1'b0;
          end else begin
            next_adsl = 1'b1;
            next_addressed = 1'b1;
            next_st = ST_DATA;
            next_tx_loaded = 1'b0;
          end
        end
        ST_DATA: begin
          if (tra) begin
            if (tx_loaded) begin
              next_bcnt = bcnt + 4'h1;
              if (bcnt == BCNT_LAST_TX) next_st = ST_DACK;
            end
          end else if (bcnt == BCNT_FULL) begin
            next_dbuf = shreg;
            next_sda_drv = ctrl[CR_ACK];
            next_st = ST_DACK;
          end
        end
        ST_DACK: begin
          next_sda_drv = 1'b0;
          next_btf = 1'b1;
          next_bcnt = BCNT_RST;
          next_st = ST_DATA;
          if (tra) next_tx_loaded = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // register stage for all groups
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_BUS_CONTROL;
      ccr <= RST_CLOCK_CONTROL;
      own_lo <= RST_OWN_LOW;
      own_hi <= RST_OWN_HIGH;
      prdata <= RST_PRDATA;
      st <= ST_IDLE;
      bcnt <= BCNT_RST;
      shreg <= RST_BYTE_BUFFER;
      dbuf <= RST_BYTE_BUFFER;
      {tx_loaded, sda_drv, ten_hdr, ten_ok, hdr_pend, addressed} <= 6'h00;
      {busy, btf, adsl, tra, af, stop_detected_flag, bus_error_flag, general_call_flag} <= 8'h00;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      ccr <= next_ccr;
      own_lo <= next_own_lo;
      own_hi <= next_own_hi;
      prdata <= next_prdata;
      st <= next_st;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      dbuf <= next_dbuf;
      {tx_loaded, sda_drv, ten_hdr, ten_ok, hdr_pend, addressed} <=
        {next_tx_loaded, next_sda_drv, next_ten_hdr, next_ten_ok, next_hdr_pend, next_addressed};
      {busy, btf, adsl, tra, af, stop_detected_flag, bus_error_flag, general_call_flag} <=
        {next_busy, next_btf, next_adsl, next_tra, next_af, next_stop_detected_flag, next_bus_error_flag, next_general_call_flag};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // checks on flags, pins and configuration
  a_bus_error_flag_on_misplaced:
    assert property (pe && start_c && misplaced |=> bus_error_flag && !busy)
      else $error("misplaced start did not flag bus error");
  a_irq_from_bus_error_flag:
    assert property (bus_error_flag && ctrl[CR_ITE] |-> irq)
      else $error("bus error with interrupts on gave no irq");
  a_bus_error_flag_read_clear:
    assert property (pe && bus_error_flag && rd_acc && hit(paddr, IDX_STATUS_SECOND)
      && !start_c && !stop_c |=> !bus_error_flag)
      else $error("status_second read left bus error set");
  a_bus_error_flag_no_stretch:
    assert property (bus_error_flag && !adsl && !btf && !tx_wait |-> !scl_oe)
      else $error("scl held low by bus error alone");
  a_general_call_flag_set:
    assert property (a_eval && !ten_hdr && shreg == GEN_CALL_ADDR && ctrl[CR_GENERAL_CALL_ENABLE] |=> general_call_flag)
      else $error("general call not flagged");
  a_general_call_flag_stop_clear:
    assert property (pe && stop_c |=> !general_call_flag && !busy ##1 !general_call_flag)
      else $error("general call flag survived stop");
  a_cfg_kept:
    assert property (!wr_ok |=> $stable(ccr) && $stable(own_lo))
      else $error("configuration changed without a write");
  a_rx_hold:
    assert property (pe && btf && !tra |-> scl_oe ##1 (scl_oe || !btf))
      else $error("receiver released scl before byte buffer read");
  a_never_01:
    assert property (a_eval && !ten_hdr && shreg == NEVER_ADDR |=> st == ST_SKIP && !sda_drv)
      else $error("address 01h was acknowledged");
  a_busy_on_bus_error_flag:
    assert property ($rose(bus_error_flag) |-> !busy)
      else $error("bus busy still set after bus error");
  a_ite_off_disabled:
    assert property (!ctrl[CR_PE] |-> !ctrl[CR_ITE] && !irq)
      else $error("interrupt enable set while peripheral disabled");
endmodule
`default_nettype wire

// [logic/isc_pin_sync.sv]
// isc_pin_sync: three-stage synchroniser with an agreement filter per pin
// assumes pins idle high, as on an open-drain bus with pull-ups
`timescale 1ns/1ps
`default_nettype none
module isc_pin_sync
  import isc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire logic [WIDTH-1:0] next_level;

  // level moves only once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign next_level[g] = (s2[g] == s3[g]) ? s2[g] : level[g];
    end
  endgenerate

  // stage chain; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      level <= '1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// [logic/isc_pkg.sv]
// isc_pkg: register indices, field positions, reset values and engine states
// assumes byte-wide registers behind a 32-bit apb slave on a 100 MHz pclk
package isc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_BUS_CONTROL = 8'h28;
  localparam logic [7:0] IDX_STATUS_FIRST = 8'h29;
  localparam logic [7:0] IDX_STATUS_SECOND = 8'h2a;
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h2b;
  localparam logic [7:0] IDX_OWN_ADDRESS_LOW = 8'h2c;
  localparam logic [7:0] IDX_OWN_ADDRESS_HIGH = 8'h2d;
  localparam logic [7:0] IDX_BYTE_BUFFER = 8'h2e;

  // bus_control fields
  localparam int CR_PE = 5;
  localparam int CR_GENERAL_CALL_ENABLE = 4;
  localparam int CR_ACK = 2;
  localparam int CR_ITE = 0;

  // clock_control fields
  localparam int CCR_FAST = 7;

  // own_address_high fields and writable bits
  localparam int OAH_FR_LSB = 6;
  localparam int OAH_ADDR_LSB = 1;
  localparam logic [7:0] OAH_WMASK = 8'hc6;

  // values after reset
  localparam logic [7:0] RST_BUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_OWN_LOW = 8'h00;
  localparam logic [7:0] RST_OWN_HIGH = 8'h40;
  localparam logic [7:0] RST_BYTE_BUFFER = 8'h00;
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

  // special address bytes
  localparam logic [4:0] TEN_BIT_TAG = 5'h1e;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [7:0] NEVER_ADDR = 8'h01;

  // bit counter values
  localparam logic [3:0] BCNT_RST = 4'h0;
  localparam logic [3:0] BCNT_ONE = 4'h1;
  localparam logic [3:0] BCNT_LAST_TX = 4'h7;
  localparam logic [3:0] BCNT_FULL = 4'h8;

  // scl period mapping defaults, in pclk cycles
  localparam int STD_BASE_CYC = 40;
  localparam int STD_STEP_CYC = 4;
  localparam int FAST_BASE_CYC = 12;
  localparam int FAST_STEP_CYC = 2;
  localparam logic [15:0] RATE_CNT_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h2,
    ST_DATA = 3'h3,
    ST_DACK = 3'h4,
    ST_SKIP = 3'h5
  } isc_state_t;
endpackage

// [logic/isc_scl_rate.sv]
// isc_scl_rate: bus clock rate tick from divider and speed mode
// assumes the mapping constants suit the pclk rate of the system
`timescale 1ns/1ps
`default_nettype none
module isc_scl_rate
  import isc_pkg::*;
#(
  parameter int STD_BASE = STD_BASE_CYC,
  parameter int STD_STEP = STD_STEP_CYC,
  parameter int FAST_BASE = FAST_BASE_CYC,
  parameter int FAST_STEP = FAST_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic fast_mode,
  input wire logic [6:0] divider,
  output logic tick
);
  logic [15:0] period;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_tick;

  // period grows with the divider, the mode picks base and slope
  always_comb begin
    if (fast_mode) begin
      period = 16'(FAST_BASE + FAST_STEP * int'(divider));
    end else begin
      period = 16'(STD_BASE + STD_STEP * int'(divider));
    end
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!enable) begin
      next_cnt = RATE_CNT_RST;
    end else if (cnt >= period - 16'h0001) begin
      next_cnt = RATE_CNT_RST;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // counter and tick registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= RATE_CNT_RST;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire
